//--- pkg/csc_pkg.sv
// constants, types and decode helpers for the core system-control register bank
package csc_pkg;

  // register byte offsets on the plain register port
  localparam logic [7:0] CSC_OFS_ALU_STATUS_FLAGS   = 8'h00;
  localparam logic [7:0] CSC_OFS_STACK_POINTER      = 8'h02;
  localparam logic [7:0] CSC_OFS_CLOCK_MODE_CONTROL = 8'h03;
  localparam logic [7:0] CSC_OFS_INT_ENABLE_MASK    = 8'h04;
  localparam logic [7:0] CSC_OFS_INT_REQUEST_FLAGS  = 8'h05;
  localparam logic [7:0] CSC_OFS_SIXTEEN_BIT_TIMER  = 8'h06;
  localparam logic [7:0] CSC_OFS_ANALOG_POWER_DOWN  = 8'h0A;

  // values after reset
  localparam logic [3:0] CSC_RST_FLAGS    = 4'h0;
  localparam logic [7:0] CSC_RST_SP       = 8'h00;
  localparam logic [7:0] CSC_RST_CLKMD    = 8'hF6;
  localparam logic [7:0] CSC_RST_INTEN    = 8'h00;
  localparam logic [7:0] CSC_RST_INTRQ    = 8'h00;
  localparam logic [7:0] CSC_RST_SIXTEEN_BIT_TIMER_MODE     = 8'h00;
  localparam logic       CSC_RST_ANA_PD   = 1'b0;

  // status flag positions and the constant upper nibble
  localparam int         CSC_FLG_ZERO     = 0;
  localparam int         CSC_FLG_CARRY    = 1;
  localparam int         CSC_FLG_HALF     = 2;
  localparam int         CSC_FLG_WRAP     = 3;
  localparam logic [3:0] CSC_FLG_UPPER    = 4'hF;

  // clock mode field positions
  localparam int         CSC_CLK_SEL_LSB  = 5;
  localparam int         CSC_CLK_FAST_EN  = 4;
  localparam int         CSC_CLK_TYPE     = 3;
  localparam int         CSC_CLK_SLOW_EN  = 2;
  localparam int         CSC_CLK_WDT_EN   = 1;
  localparam int         CSC_CLK_PIN_RST  = 0;

  // interrupt bit positions; the odd bits are unused
  localparam int         CSC_INT_SECOND_TIMER   = 6;
  localparam int         CSC_INT_COMP     = 4;
  localparam int         CSC_INT_SIXTEEN_BIT_TIMER  = 2;
  localparam int         CSC_INT_PIN0     = 0;
  localparam logic [7:0] CSC_INT_USED     = 8'h55;

  // sixteen-bit timer mode field positions
  localparam int         CSC_T16_SRC_LSB  = 5;
  localparam int         CSC_T16_DIV_LSB  = 3;
  localparam int         CSC_T16_BIT_BASE = 8;

  typedef enum logic [2:0] {
    CSC_OP_ADD, CSC_OP_SUB, CSC_OP_AND, CSC_OP_OR, CSC_OP_XOR, CSC_OP_SLC, CSC_OP_SRC
  } csc_alu_op_t;

  typedef enum logic [1:0] {
    CSC_SRC_FAST, CSC_SRC_SLOW, CSC_SRC_NONE
  } csc_clk_src_t;

  typedef struct packed {
    csc_clk_src_t src;
    logic [2:0]   div_log2;
    logic         rsvd;
  } csc_clk_cfg_t;

  // system clock select decode for both encoding tables
  function automatic csc_clk_cfg_t csc_decode_sysclk(input logic typ, input logic [2:0] sel);
    csc_clk_cfg_t c;
    c = '{src: CSC_SRC_NONE, div_log2: 3'h0, rsvd: 1'b1};
    if (!typ) begin
      unique case (sel)
        3'h0: c = '{src: CSC_SRC_FAST, div_log2: 3'h2, rsvd: 1'b0};
        3'h1: c = '{src: CSC_SRC_FAST, div_log2: 3'h1, rsvd: 1'b0};
        3'h6: c = '{src: CSC_SRC_SLOW, div_log2: 3'h2, rsvd: 1'b0};
        3'h7: c = '{src: CSC_SRC_SLOW, div_log2: 3'h0, rsvd: 1'b0};
        default: c = '{src: CSC_SRC_NONE, div_log2: 3'h0, rsvd: 1'b1};
      endcase
    end else begin
      unique case (sel)
        3'h0: c = '{src: CSC_SRC_FAST, div_log2: 3'h4, rsvd: 1'b0};
        3'h1: c = '{src: CSC_SRC_FAST, div_log2: 3'h3, rsvd: 1'b0};
        3'h2: c = '{src: CSC_SRC_SLOW, div_log2: 3'h4, rsvd: 1'b0};
        3'h3: c = '{src: CSC_SRC_FAST, div_log2: 3'h5, rsvd: 1'b0};
        3'h4: c = '{src: CSC_SRC_FAST, div_log2: 3'h6, rsvd: 1'b0};
        default: c = '{src: CSC_SRC_NONE, div_log2: 3'h0, rsvd: 1'b1};
      endcase
    end
    return c;
  endfunction

endpackage

//--- rtl/csc_alu_flags.sv
// combinational result and flag evaluation for one alu operation
`timescale 1ns/1ps
module csc_alu_flags
  import csc_pkg::*;
(
  // operation
  input  wire csc_alu_op_t op_i,
  input  wire logic [7:0]  a_i,
  input  wire logic [7:0]  b_i,
  input  wire logic        carry_i,
  // result and flags
  output logic      [7:0]  res_o,
  output logic      [3:0]  flags_o,
  output logic      [3:0]  upd_o
);

  logic [8:0] sum;
  logic [4:0] low;

  always_comb begin
    sum     = 9'h000;
    low     = 5'h00;
    res_o   = 8'h00;
    flags_o = 4'h0;
    upd_o   = 4'h0;
    unique case (op_i)
      CSC_OP_ADD: begin
        sum   = {1'b0, a_i} + {1'b0, b_i};
        low   = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
        res_o = sum[7:0];
        // [R2] signed wrap on add
        flags_o[CSC_FLG_WRAP]  = (a_i[7] == b_i[7]) && (sum[7] != a_i[7]);
        // [R3] low nibble carry
        flags_o[CSC_FLG_HALF]  = low[4];
        // [R4] carry out of add
        flags_o[CSC_FLG_CARRY] = sum[8];
        upd_o = 4'hF;
      end
      CSC_OP_SUB: begin
        sum   = {1'b0, a_i} - {1'b0, b_i};
        low   = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]};
        res_o = sum[7:0];
        // [R2] signed wrap on subtract
        flags_o[CSC_FLG_WRAP]  = (a_i[7] != b_i[7]) && (sum[7] != a_i[7]);
        // [R3] borrow into low nibble
        flags_o[CSC_FLG_HALF]  = low[4];
        // [R4] borrow on subtract
        flags_o[CSC_FLG_CARRY] = sum[8];
        upd_o = 4'hF;
      end
      CSC_OP_AND: begin
        res_o = a_i & b_i;
        upd_o = 4'h1;
      end
      CSC_OP_OR: begin
        res_o = a_i | b_i;
        upd_o = 4'h1;
      end
      CSC_OP_XOR: begin
        res_o = a_i ^ b_i;
        upd_o = 4'h1;
      end
      CSC_OP_SLC: begin
        // [R4] shift left through carry
        res_o = {a_i[6:0], carry_i};
        flags_o[CSC_FLG_CARRY] = a_i[7];
        upd_o = 4'h2;
      end
      CSC_OP_SRC: begin
        // [R4] shift right through carry
        res_o = {carry_i, a_i[7:1]};
        flags_o[CSC_FLG_CARRY] = a_i[0];
        upd_o = 4'h2;
      end
      default: begin
        res_o = 8'h00;
        upd_o = 4'h0;
      end
    endcase
    // [R5] zero on arithmetic or logic result
    flags_o[CSC_FLG_ZERO] = (res_o == 8'h00);
  end

endmodule

//--- rtl/csc_core_regs.sv
// core system-control register bank: flags, stack pointer, clock, interrupts, timer mode
// Notes on behaviour
// [R1] status register upper four bits always read back as ones
// [R2] signed wrap flag set when a signed operation overflows
// [R3] half carry set on low nibble carry or borrow into low nibble
// [R4] carry set on add carry or subtract borrow, also by shift through carry
// [R5] zero flag set on zero arithmetic or logic result, cleared otherwise
// [R6] stack pointer reads current value and writes replace it
// [R7] software keeps stack pointer bit zero at zero
// [R8] clock select field resets to 111 and decodes per selected table
// [R9] clock mode bit 3 resets low and picks the clock table
// [R10] clock mode bit 4 resets high and enables the fast oscillator
// [R11] bit 2 enables slow oscillator; when low watchdog is forced off
// [R12] clock mode bit 1 resets high and enables the watchdog
// [R13] clock mode bit 0 picks port pin five or external reset pin
// [R14] interrupt enable bits 6, 4, 2, 0 allow their sources
// [R15] request bits set by hardware events and held until software clears
// [R16] timer source field and prescaler select timer clock and division
// [R17] timer mode low bits pick counter bit 8..15 whose change raises event
// [R18] analog power bit powers down reference and brownout detector
// [R19] software writes zeros to unused analog power bits
// [R20] unused interrupt bits ignore writes and read as zero
`timescale 1ns/1ps
module csc_core_regs
  import csc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wr_data_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rd_data_o,
  // alu operation from the cpu
  input  wire logic        alu_valid_i,
  input  wire csc_alu_op_t alu_op_i,
  input  wire logic [7:0]  alu_a_i,
  input  wire logic [7:0]  alu_b_i,
  output logic      [7:0]  alu_res_o,
  output logic      [3:0]  flags_o,
  // interrupt events from same-clock logic
  input  wire logic        second_timer_evt_i,
  input  wire logic        comparator_evt_i,
  input  wire logic        port_a_pin_zero_evt_i,
  input  wire logic [15:0] sixteen_bit_timer_count_i,
  output logic      [7:0]  int_req_o,
  output logic             irq_pending_o,
  // system control outputs
  output logic      [7:0]  stack_pointer_o,
  output logic             fast_rc_osc_en_o,
  output logic             slow_rc_osc_en_o,
  output logic             wdt_en_o,
  output logic             external_reset_pin_sel_o,
  output csc_clk_src_t     sys_clk_src_o,
  output logic      [2:0]  sys_clk_div_log2_o,
  output logic             sys_clk_rsvd_o,
  output logic      [2:0]  sixteen_bit_timer_src_o,
  output logic      [2:0]  sixteen_bit_timer_div_log2_o,
  output logic             analog_pd_o
);

  // register state
  logic [3:0]   flags_ff,   nxt_flags;
  logic [7:0]   sp_ff,      nxt_sp;
  logic [7:0]   clkmd_ff,   nxt_clkmd;
  logic [7:0]   inten_ff,   nxt_inten;
  logic [7:0]   intrq_ff,   nxt_intrq;
  logic [7:0]   sixteen_bit_timer_mode_ff,    nxt_sixteen_bit_timer_mode;
  logic         ana_pd_ff,  nxt_ana_pd;
  logic [7:0]   rdata_ff,   nxt_rdata;
  logic [7:0]   alu_res_ff, nxt_alu_res;
  logic [7:0]   cnt_hi_ff;
  // derived output state
  logic         irq_ff,     nxt_irq;
  logic         wdt_ff,     nxt_wdt;
  csc_clk_cfg_t clk_cfg_ff, nxt_clk_cfg;

  logic [7:0] alu_res;
  logic [3:0] alu_flags;
  logic [3:0] alu_upd;
  logic [7:0] evt_vec;
  logic [2:0] t16_bit_sel;
  logic       t16_evt;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  csc_alu_flags u_alu (
    .op_i    (alu_op_i),
    .a_i     (alu_a_i),
    .b_i     (alu_b_i),
    .carry_i (flags_ff[CSC_FLG_CARRY]),
    .res_o   (alu_res),
    .flags_o (alu_flags),
    .upd_o   (alu_upd)
  );

  // [R17] selected counter bit change
  assign t16_bit_sel = sixteen_bit_timer_mode_ff[2:0];
  assign t16_evt     = sixteen_bit_timer_count_i[CSC_T16_BIT_BASE + int'(t16_bit_sel)]
                       ^ cnt_hi_ff[t16_bit_sel];

  always_comb begin
    evt_vec = 8'h00;
    evt_vec[CSC_INT_SECOND_TIMER]  = second_timer_evt_i;
    evt_vec[CSC_INT_COMP]    = comparator_evt_i;
    evt_vec[CSC_INT_SIXTEEN_BIT_TIMER] = t16_evt;
    evt_vec[CSC_INT_PIN0]    = port_a_pin_zero_evt_i;
  end

  // register writes and hardware updates
  always_comb begin
    nxt_flags   = flags_ff;
    nxt_sp      = sp_ff;
    nxt_clkmd   = clkmd_ff;
    nxt_inten   = inten_ff;
    nxt_intrq   = intrq_ff;
    nxt_sixteen_bit_timer_mode    = sixteen_bit_timer_mode_ff;
    nxt_ana_pd  = ana_pd_ff;
    nxt_alu_res = alu_res_ff;
    if (wr_i) begin
      if (hit(addr_i, CSC_OFS_ALU_STATUS_FLAGS)) begin
        nxt_flags = wr_data_i[3:0];
      end
      // [R6] write replaces stack pointer
      if (hit(addr_i, CSC_OFS_STACK_POINTER)) begin
        nxt_sp = wr_data_i;
      end
      if (hit(addr_i, CSC_OFS_CLOCK_MODE_CONTROL)) begin
        nxt_clkmd = wr_data_i;
      end
      // [R20] unused enable bits dropped
      if (hit(addr_i, CSC_OFS_INT_ENABLE_MASK)) begin
        nxt_inten = wr_data_i & CSC_INT_USED;
      end
      if (hit(addr_i, CSC_OFS_INT_REQUEST_FLAGS)) begin
        nxt_intrq = wr_data_i & CSC_INT_USED;
      end
      if (hit(addr_i, CSC_OFS_SIXTEEN_BIT_TIMER)) begin
        nxt_sixteen_bit_timer_mode = wr_data_i;
      end
      // [R18] only bit 0 stored
      if (hit(addr_i, CSC_OFS_ANALOG_POWER_DOWN)) begin
        nxt_ana_pd = wr_data_i[0];
      end
    end
    // alu update wins over a software write to the flags
    if (alu_valid_i) begin
      nxt_flags   = (flags_ff & ~alu_upd) | (alu_flags & alu_upd);
      nxt_alu_res = alu_res;
    end
    // [R15] hardware set wins over software clear
    nxt_intrq = nxt_intrq | (evt_vec & CSC_INT_USED);
  end

  // read data and derived outputs
  always_comb begin
    nxt_rdata = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        // [R1] upper nibble reads ones
        CSC_OFS_ALU_STATUS_FLAGS:   nxt_rdata = {CSC_FLG_UPPER, flags_ff};
        CSC_OFS_STACK_POINTER:      nxt_rdata = sp_ff;
        CSC_OFS_CLOCK_MODE_CONTROL: nxt_rdata = clkmd_ff;
        CSC_OFS_INT_ENABLE_MASK:    nxt_rdata = inten_ff & CSC_INT_USED;
        CSC_OFS_INT_REQUEST_FLAGS:  nxt_rdata = intrq_ff & CSC_INT_USED;
        CSC_OFS_SIXTEEN_BIT_TIMER:  nxt_rdata = sixteen_bit_timer_mode_ff;
        default:                    nxt_rdata = 8'h00;
      endcase
    end
    // [R14] enabled pending request
    nxt_irq     = |(nxt_intrq & nxt_inten);
    // [R11] watchdog needs slow oscillator
    nxt_wdt     = nxt_clkmd[CSC_CLK_WDT_EN] & nxt_clkmd[CSC_CLK_SLOW_EN];
    // [R8] clock select decode
    nxt_clk_cfg = csc_decode_sysclk(nxt_clkmd[CSC_CLK_TYPE], nxt_clkmd[7:CSC_CLK_SEL_LSB]);
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flags_ff   <= CSC_RST_FLAGS;
      sp_ff      <= CSC_RST_SP;
      clkmd_ff   <= CSC_RST_CLKMD;
      inten_ff   <= CSC_RST_INTEN;
      intrq_ff   <= CSC_RST_INTRQ;
      sixteen_bit_timer_mode_ff    <= CSC_RST_SIXTEEN_BIT_TIMER_MODE;
      ana_pd_ff  <= CSC_RST_ANA_PD;
      rdata_ff   <= 8'h00;
      alu_res_ff <= 8'h00;
      cnt_hi_ff  <= 8'h00;
      irq_ff     <= 1'b0;
      wdt_ff     <= 1'b1;
      clk_cfg_ff <= '{src: CSC_SRC_SLOW, div_log2: 3'h0, rsvd: 1'b0};
    end else begin
      flags_ff   <= nxt_flags;
      sp_ff      <= nxt_sp;
      clkmd_ff   <= nxt_clkmd;
      inten_ff   <= nxt_inten;
      intrq_ff   <= nxt_intrq;
      sixteen_bit_timer_mode_ff    <= nxt_sixteen_bit_timer_mode;
      ana_pd_ff  <= nxt_ana_pd;
      rdata_ff   <= nxt_rdata;
      alu_res_ff <= nxt_alu_res;
      cnt_hi_ff  <= sixteen_bit_timer_count_i[15:8];
      irq_ff     <= nxt_irq;
      wdt_ff     <= nxt_wdt;
      clk_cfg_ff <= nxt_clk_cfg;
    end
  end

  assign rd_data_o                = rdata_ff;
  assign alu_res_o                = alu_res_ff;
  assign flags_o                  = flags_ff;
  assign int_req_o                = intrq_ff;
  assign irq_pending_o            = irq_ff;
  assign stack_pointer_o          = sp_ff;
  // [R10] fast oscillator enable
  assign fast_rc_osc_en_o         = clkmd_ff[CSC_CLK_FAST_EN];
  assign slow_rc_osc_en_o         = clkmd_ff[CSC_CLK_SLOW_EN];
  // [R12] watchdog enable
  assign wdt_en_o                 = wdt_ff;
  // [R13] shared pin function
  assign external_reset_pin_sel_o = clkmd_ff[CSC_CLK_PIN_RST];
  // [R9] table chosen inside the decode
  assign sys_clk_src_o            = clk_cfg_ff.src;
  assign sys_clk_div_log2_o       = clk_cfg_ff.div_log2;
  assign sys_clk_rsvd_o           = clk_cfg_ff.rsvd;
  // [R16] timer source and prescaler
  assign sixteen_bit_timer_src_o            = sixteen_bit_timer_mode_ff[7:CSC_T16_SRC_LSB];
  assign sixteen_bit_timer_div_log2_o       = {sixteen_bit_timer_mode_ff[4:CSC_T16_DIV_LSB], 1'b0};
  assign analog_pd_o              = ana_pd_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_flag_upper_ones: assert property ( // [R1]
    rd_i && addr_i == CSC_OFS_ALU_STATUS_FLAGS |=> rd_data_o[7:4] == 4'hF)
    else $error("status upper bits not ones");
  a_wrap_on_add: assert property ( // [R2]
    alu_valid_i && alu_op_i == CSC_OP_ADD && alu_a_i == 8'h7F && alu_b_i == 8'h01
    |=> flags_o[CSC_FLG_WRAP] && alu_res_o == 8'h80)
    else $error("signed wrap not set");
  a_half_carry: assert property ( // [R3]
    alu_valid_i && alu_op_i == CSC_OP_SUB && alu_a_i[3:0] < alu_b_i[3:0]
    |=> flags_o[CSC_FLG_HALF])
    else $error("half borrow not set");
  a_carry_borrow: assert property ( // [R4]
    alu_valid_i && alu_op_i == CSC_OP_SUB
    |=> flags_o[CSC_FLG_CARRY] == ($past(alu_a_i) < $past(alu_b_i)))
    else $error("borrow flag wrong");
  a_zero_flag: assert property ( // [R5]
    alu_valid_i && alu_op_i inside {CSC_OP_ADD, CSC_OP_SUB, CSC_OP_XOR}
    |=> flags_o[CSC_FLG_ZERO] == (alu_res_o == 8'h00))
    else $error("zero flag mismatch");
  a_sp_readback: assert property ( // [R6]
    wr_i && addr_i == CSC_OFS_STACK_POINTER ##1 rd_i && addr_i == CSC_OFS_STACK_POINTER
    |=> rd_data_o == $past(wr_data_i, 2))
    else $error("stack pointer readback wrong");
  a_wdt_forced_off: assert property ( // [R11]
    !slow_rc_osc_en_o |-> !wdt_en_o)
    else $error("watchdog on without slow oscillator");
  a_req_sticky: assert property ( // [R15]
    int_req_o[CSC_INT_PIN0] && !(wr_i && addr_i == CSC_OFS_INT_REQUEST_FLAGS)
    |=> int_req_o[CSC_INT_PIN0])
    else $error("request dropped without clear");
  a_set_beats_clear: assert property ( // [R15]
    port_a_pin_zero_evt_i |=> int_req_o[CSC_INT_PIN0])
    else $error("event lost");
  a_t16_bit_event: assert property ( // [R17]
    $changed(sixteen_bit_timer_count_i[8]) && sixteen_bit_timer_mode_ff[2:0] == 3'h0 && !$changed(sixteen_bit_timer_mode_ff)
    |=> int_req_o[CSC_INT_SIXTEEN_BIT_TIMER])
    else $error("timer bit change not flagged");
  a_unused_int_zero: assert property ( // [R20]
    1'b1 |-> (int_req_o & 8'hAA) == 8'h00 && (inten_ff & 8'hAA) == 8'h00)
    else $error("unused interrupt bit set");
  a_irq_masked: assert property ( // [R14]
    inten_ff == 8'h00 |-> !irq_pending_o)
    else $error("irq without enable");
  a_irq_follows_req: assert property ( // [R14]
    int_req_o[CSC_INT_PIN0] && inten_ff[CSC_INT_PIN0] |-> irq_pending_o)
    else $error("enabled request without irq");
  a_req_clear: assert property ( // [R15]
    wr_i && addr_i == CSC_OFS_INT_REQUEST_FLAGS && !wr_data_i[CSC_INT_PIN0]
    && !port_a_pin_zero_evt_i |=> !int_req_o[CSC_INT_PIN0])
    else $error("request not cleared by software");

  // stack pointer and clock mode fields
  a_sp_write_lands: assert property ( // [R6]
    wr_i && addr_i == CSC_OFS_STACK_POINTER |=> stack_pointer_o == $past(wr_data_i))
    else $error("stack pointer write lost");
  a_sysclk_slow_div1: assert property ( // [R8]
    wr_i && addr_i == CSC_OFS_CLOCK_MODE_CONTROL && wr_data_i[7:5] == 3'h7
    && !wr_data_i[CSC_CLK_TYPE]
    |=> sys_clk_src_o == CSC_SRC_SLOW && sys_clk_div_log2_o == 3'h0 && !sys_clk_rsvd_o)
    else $error("type 0 code 7 not slow undivided");
  a_type1_slow_16: assert property ( // [R9]
    wr_i && addr_i == CSC_OFS_CLOCK_MODE_CONTROL && wr_data_i[7:5] == 3'h2
    && wr_data_i[CSC_CLK_TYPE]
    |=> sys_clk_src_o == CSC_SRC_SLOW && sys_clk_div_log2_o == 3'h4 && !sys_clk_rsvd_o)
    else $error("type 1 code 2 not slow by 16");
  a_fast_osc_off: assert property ( // [R10]
    wr_i && addr_i == CSC_OFS_CLOCK_MODE_CONTROL && !wr_data_i[CSC_CLK_FAST_EN]
    |=> !fast_rc_osc_en_o)
    else $error("fast oscillator still enabled");
  a_slow_osc_off: assert property ( // [R11]
    wr_i && addr_i == CSC_OFS_CLOCK_MODE_CONTROL && !wr_data_i[CSC_CLK_SLOW_EN]
    |=> !slow_rc_osc_en_o && !wdt_en_o)
    else $error("slow oscillator off but watchdog on");
  a_wdt_off: assert property ( // [R12]
    wr_i && addr_i == CSC_OFS_CLOCK_MODE_CONTROL && !wr_data_i[CSC_CLK_WDT_EN]
    |=> !wdt_en_o)
    else $error("watchdog still enabled");
  a_pin_reset_sel: assert property ( // [R13]
    wr_i && addr_i == CSC_OFS_CLOCK_MODE_CONTROL && wr_data_i[CSC_CLK_PIN_RST]
    |=> external_reset_pin_sel_o)
    else $error("shared pin not external reset");

  // timer mode and analog power fields
  a_t16_src_field: assert property ( // [R16]
    wr_i && addr_i == CSC_OFS_SIXTEEN_BIT_TIMER && wr_data_i[7:5] == 3'h7
    |=> sixteen_bit_timer_src_o == 3'h7)
    else $error("timer source field wrong");
  a_t16_div_field: assert property ( // [R16]
    wr_i && addr_i == CSC_OFS_SIXTEEN_BIT_TIMER && wr_data_i[4:3] == 2'h3
    |=> sixteen_bit_timer_div_log2_o == 3'h6)
    else $error("timer prescaler not 64");
  a_analog_down: assert property ( // [R18]
    wr_i && addr_i == CSC_OFS_ANALOG_POWER_DOWN && wr_data_i[0] |=> analog_pd_o)
    else $error("analog power down not taken");
  a_wo_read_zero: assert property ( // [R18]
    rd_i && addr_i == CSC_OFS_ANALOG_POWER_DOWN |=> rd_data_o == 8'h00)
    else $error("write-only register read nonzero");

  c_wdt_disable:  cover property (wr_i && addr_i == CSC_OFS_CLOCK_MODE_CONTROL ##1 !wdt_en_o);
  c_irq_raise:    cover property (!irq_pending_o ##1 irq_pending_o);
  c_type1_clock:  cover property (clkmd_ff[CSC_CLK_TYPE] && !sys_clk_rsvd_o);
  c_analog_down:  cover property (analog_pd_o);
  c_t16_event:    cover property (t16_evt);

endmodule

//--- test/csc_core_regs_tb.sv
// self-checking testbench for the core system-control register bank
`timescale 1ns/1ps
module csc_core_regs_tb;
  import csc_pkg::*;

  logic        clk;
  logic        rst_b;
  logic [7:0]  addr;
  logic [7:0]  wr_data;
  logic        wr;
  logic        rd;
  logic [7:0]  rd_data;
  logic        alu_valid;
  csc_alu_op_t alu_op;
  logic [7:0]  alu_a;
  logic [7:0]  alu_b;
  logic [7:0]  alu_res;
  logic [3:0]  flags;
  logic [2:0]  ev_vec;
  logic [15:0] t16_cnt;
  logic [7:0]  int_req;
  logic        irq;
  logic [7:0]  sp;
  logic        fast_en;
  logic        slow_en;
  logic        wdt_en;
  logic        ext_rst;
  csc_clk_src_t clk_src;
  logic [2:0]  clk_div;
  logic        clk_rsvd;
  logic [2:0]  t16_src;
  logic [2:0]  t16_div;
  logic        ana_pd;
  int          n_fail;
  int          n_compared;
  logic [7:0]  rst_addr [9];
  logic [7:0]  rst_exp  [9];

  csc_core_regs i_csc_core_regs (
    .clk_i                    (clk),
    .rst_b_i                  (rst_b),
    .addr_i                   (addr),
    .wr_data_i                (wr_data),
    .wr_i                     (wr),
    .rd_i                     (rd),
    .rd_data_o                (rd_data),
    .alu_valid_i              (alu_valid),
    .alu_op_i                 (alu_op),
    .alu_a_i                  (alu_a),
    .alu_b_i                  (alu_b),
    .alu_res_o                (alu_res),
    .flags_o                  (flags),
    .second_timer_evt_i       (ev_vec[0]),
    .comparator_evt_i         (ev_vec[1]),
    .port_a_pin_zero_evt_i    (ev_vec[2]),
    .sixteen_bit_timer_count_i          (t16_cnt),
    .int_req_o                (int_req),
    .irq_pending_o            (irq),
    .stack_pointer_o          (sp),
    .fast_rc_osc_en_o         (fast_en),
    .slow_rc_osc_en_o         (slow_en),
    .wdt_en_o                 (wdt_en),
    .external_reset_pin_sel_o (ext_rst),
    .sys_clk_src_o            (clk_src),
    .sys_clk_div_log2_o       (clk_div),
    .sys_clk_rsvd_o           (clk_rsvd),
    .sixteen_bit_timer_src_o            (t16_src),
    .sixteen_bit_timer_div_log2_o       (t16_div),
    .analog_pd_o              (ana_pd)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr      <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge clk);
    wr      <= 1'b0;
    #1;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask

  task automatic alu_run(input csc_alu_op_t op, input logic [7:0] a, input logic [7:0] b,
                         input logic [7:0] res, input logic [3:0] f);
    @(posedge clk);
    alu_valid <= 1'b1;
    alu_op    <= op;
    alu_a     <= a;
    alu_b     <= b;
    @(posedge clk);
    alu_valid <= 1'b0;
    #1;
    chk(alu_res, res);
    chk({4'h0, flags}, {4'h0, f});
  endtask

  task automatic pulse_ev(input logic [2:0] v);
    @(posedge clk);
    ev_vec <= v;
    @(posedge clk);
    ev_vec <= 3'h0;
    #1;
  endtask

  // expected {src, div_log2, reserved} for each clock select code
  function automatic logic [7:0] exp_clk(input logic [3:0] ts);
    case (ts)
      4'h0: return 8'h04;
      4'h1: return 8'h02;
      4'h6: return 8'h14;
      4'h7: return 8'h10;
      4'h8: return 8'h08;
      4'h9: return 8'h06;
      4'hA: return 8'h18;
      4'hB: return 8'h0A;
      4'hC: return 8'h0C;
      default: return 8'h21;
    endcase
  endfunction

  initial begin
    #100000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    rst_b = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wr_data = 8'h00;
    alu_valid = 1'b0; alu_op = CSC_OP_ADD; alu_a = 8'h00; alu_b = 8'h00;
    ev_vec = 3'h0; t16_cnt = 16'h0000; n_fail = 0; n_compared = 0;
    rst_addr = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0A, 8'h0B};
    rst_exp  = '{8'hF0, 8'h00, 8'h00, 8'hF6, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk({4'h0, fast_en, slow_en, wdt_en, ext_rst}, 8'h0E);
    chk({2'h0, clk_src, clk_div, clk_rsvd}, 8'h10);
    for (int i = 0; i < 9; i++) begin
      rd_reg(rst_addr[i], rst_exp[i]);
    end
    @(posedge clk);
    #1;
    chk(rd_data, 8'h00);
    // stack pointer, unmapped write ignored
    wr_reg(8'h02, 8'h20);
    rd_reg(8'h02, 8'h20);
    chk(sp, 8'h20);
    wr_reg(8'h01, 8'h55);
    rd_reg(8'h02, 8'h20);
    // write then read with no gap
    @(posedge clk);
    wr      <= 1'b1;
    addr    <= 8'h02;
    wr_data <= 8'h3C;
    @(posedge clk);
    wr      <= 1'b0;
    rd      <= 1'b1;
    @(posedge clk);
    rd      <= 1'b0;
    #1;
    chk(rd_data, 8'h3C);
    // every alu operation and flag update
    alu_run(CSC_OP_ADD, 8'h7F, 8'h01, 8'h80, 4'hC);
    alu_run(CSC_OP_ADD, 8'hFF, 8'h01, 8'h00, 4'h7);
    alu_run(CSC_OP_SUB, 8'h00, 8'h01, 8'hFF, 4'h6);
    alu_run(CSC_OP_SUB, 8'h80, 8'h01, 8'h7F, 4'hC);
    alu_run(CSC_OP_AND, 8'hF0, 8'h0F, 8'h00, 4'hD);
    alu_run(CSC_OP_OR,  8'h01, 8'h00, 8'h01, 4'hC);
    alu_run(CSC_OP_XOR, 8'hAA, 8'hAA, 8'h00, 4'hD);
    alu_run(CSC_OP_SRC, 8'h01, 8'h01, 8'h00, 4'hF);
    alu_run(CSC_OP_SLC, 8'h40, 8'h40, 8'h81, 4'hD);
    rd_reg(8'h00, 8'hFD);
    wr_reg(8'h00, 8'h0A);
    rd_reg(8'h00, 8'hFA);
    // both clock tables, all select codes
    for (int i = 0; i < 16; i++) begin
      wr_reg(8'h03, {i[2:0], 1'b1, i[3], 3'b110});
      chk({2'h0, clk_src, clk_div, clk_rsvd}, exp_clk(i[3:0]));
      rd_reg(8'h03, {i[2:0], 1'b1, i[3], 3'b110});
    end
    wr_reg(8'h03, 8'hF2);
    chk({4'h0, fast_en, slow_en, wdt_en, ext_rst}, 8'h08);
    wr_reg(8'h03, 8'hE7);
    chk({4'h0, fast_en, slow_en, wdt_en, ext_rst}, 8'h07);
    wr_reg(8'h03, 8'hF4);
    chk({4'h0, fast_en, slow_en, wdt_en, ext_rst}, 8'h0C);
    // interrupt enable, request latching and clearing
    wr_reg(8'h04, 8'hFF);
    rd_reg(8'h04, 8'h55);
    pulse_ev(3'h1);
    pulse_ev(3'h2);
    pulse_ev(3'h4);
    repeat (4) @(posedge clk);
    #1;
    chk(int_req, 8'h51);
    chk({7'h0, irq}, 8'h01);
    rd_reg(8'h05, 8'h51);
    wr_reg(8'h05, 8'h50);
    chk(int_req, 8'h50);
    wr_reg(8'h05, 8'h00);
    chk({int_req[7:1], irq}, 8'h00);
    wr_reg(8'h04, 8'h00);
    pulse_ev(3'h4);
    @(posedge clk);
    #1;
    chk({int_req[7:1], irq}, 8'h00);
    chk({7'h0, int_req[0]}, 8'h01);
    @(posedge clk);
    wr      <= 1'b1;
    addr    <= 8'h05;
    wr_data <= 8'h00;
    ev_vec  <= 3'h4;
    @(posedge clk);
    wr      <= 1'b0;
    ev_vec  <= 3'h0;
    #1;
    chk(int_req, 8'h01);
    wr_reg(8'h05, 8'h00);
    // timer mode fields and selected counter bit
    wr_reg(8'h06, 8'hFB);
    rd_reg(8'h06, 8'hFB);
    chk({2'h0, t16_src, t16_div}, 8'h3E);
    wr_reg(8'h04, 8'h04);
    @(posedge clk);
    t16_cnt <= 16'h0400;
    repeat (3) @(posedge clk);
    #1;
    chk({int_req[7:1], irq}, 8'h00);
    @(posedge clk);
    t16_cnt <= 16'h0C00;
    repeat (2) @(posedge clk);
    #1;
    chk({int_req[7:1], irq}, 8'h05);
    wr_reg(8'h05, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    chk(int_req, 8'h00);
    wr_reg(8'h06, 8'h20);
    @(posedge clk);
    t16_cnt <= 16'h0D00;
    repeat (2) @(posedge clk);
    #1;
    chk(int_req, 8'h04);
    // write-only analog power control
    wr_reg(8'h0A, 8'h01);
    chk({7'h0, ana_pd}, 8'h01);
    rd_reg(8'h0A, 8'h00);
    wr_reg(8'h0A, 8'h00);
    chk({7'h0, ana_pd}, 8'h00);
    report_and_stop();
  end
endmodule
